// File: hw/ildm_pkg.sv
// Constants for the link delay monitor: register indices, fields, reset values
// Function
// [RL1] Selection write refreshes result and link number two cycles later, 11-bit delay.
// [RL2] Types: max over time, group current max, group current min, single link delay.
// [RL3] Link delay is write pointer minus its group's read pointer.
// [RL4] Group start puts read pointer at slowest link minus guardband.
// [RL5] Software keeps each group guardband small, never below 4 cells.
// [RL6] Running, the slowest link's delay equals the guardband.
// [RL7] Each link delay is checked against its own group's maximum operational delay.
// [RL8] Software sets maximum operational delay between four cells and memory capacity.
// [RL9] Too slow an added link gives sync loss and a negative delay.
// [RL10] Too fast a link, beyond maximum delay, gives sync loss; recombination continues.
// [RL11] Sync loss also raised when a running link drifts negative or beyond maximum.
// [RL12] Onset and end of sync loss latch status bits, enable-gated interrupt.
// [RL13] Enabling a negative-delay link suspends recombination until delay reaches 4.
// [RL14] A participating link going negative suspends recombination until delay reaches 4.
// [RL15] Clear bit 6 of selection resets max over time, reading 0xFE00.
// [RL16] Delays are cell counts including guardband; link number zero for max over time.
// [RL17] Negative delays carry a sign prefix so negative zero differs from zero.
package ildm_pkg;
    localparam int NLINK = 4;
    localparam int NGRP  = 4;
    localparam int DW    = 11;

    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_DELAY_RESULT = 12'h285;
    localparam logic [11:0] IDX_DELAY_LINK   = 12'h286;
    localparam logic [11:0] IDX_GUARD_BASE   = 12'h287;
    localparam logic [11:0] IDX_MAXOP_BASE   = 12'h29A;
    localparam logic [11:0] IDX_DELAY_SEL    = 12'h2AA;
    localparam logic [11:0] IDX_IRQ_STS      = 12'h435;
    localparam logic [11:0] IDX_IRQ_CLR      = 12'h436;
    localparam logic [11:0] IDX_IRQ_EN       = 12'h437;
    localparam logic [11:0] IDX_LINK_CTL     = 12'h438;
    localparam logic [11:0] IDX_GRP_RUN      = 12'h439;
    localparam logic [11:0] IDX_SUSP_STS     = 12'h43A;

    // Selection register fields
    localparam int SEL_NUM_LSB  = 0;
    localparam int SEL_TYPE_LSB = 4;
    localparam int SEL_CLR_BIT  = 6;
    localparam logic [15:0] SEL_WMASK = 16'h003F;

    // Link control: four bits per link
    localparam int LCTL_W          = 4;
    localparam int LCTL_GRP_LSB    = 0;
    localparam int LCTL_MEMBER_BIT = 2;
    localparam int LCTL_RECOMB_BIT = 3;

    // Status layout: onset bits then end bits
    localparam int STS_ONSET_LSB = 0;
    localparam int STS_END_LSB   = 4;

    // Reset values
    localparam logic [15:0] GUARD_RST = 16'h0004;
    localparam logic [15:0] MAXOP_RST = 16'h07FF;
    localparam logic [15:0] SEL_RST   = 16'h0000;

    // Delay encoding
    localparam logic [15:0] NEG_ZERO    = 16'hFE00;
    localparam logic [6:0]  NEG_PREFIX  = 7'h7F;
    localparam logic [10:0] RESUME_CELLS = 11'h004;
    localparam int          RESULT_LAT  = 2;

    typedef enum logic [1:0] {
        ILDM_MAX_OVER_TIME = 2'h0,
        ILDM_GRP_CUR_MAX   = 2'h1,
        ILDM_GRP_CUR_MIN   = 2'h2,
        ILDM_LINK_CUR      = 2'h3
    } ildm_sel_type_e;
endpackage : ildm_pkg

// File: hw/ildm_top.sv
// Link differential delay monitor with APB register slave
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ildm_top (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [13:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Cell memory pointers to and from recombiner logic
    input  wire logic [3:0][10:0]      link_wr_ptr,
    input  wire logic [3:0]            grp_rd_adv,
    input  wire logic                  frame_tick,
    output logic      [3:0][10:0]      grp_rd_ptr,
    output logic      [3:0]            grp_suspend,
    // Interrupt
    output logic                       irq
);

    typedef struct packed {
        logic [15:0]       sel;
        logic [3:0][15:0]  guard;
        logic [3:0][15:0]  maxop;
        logic [15:0]       lctl;
        logic [7:0]        irq_en;
        logic [7:0]        sts;
        logic [3:0]        sync_loss;
        logic [3:0]        run;
        logic [3:0]        susp;
        logic [3:0][10:0]  rd;
        logic [3:0][10:0]  maxt;
        logic [3:0]        maxt_v;
        logic [15:0]       res;
        logic [15:0]       res_ln;
        logic [1:0]        pend;
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
        logic              irq;
    } ildm_state_s;

    ildm_state_s st_r;
    ildm_state_s st_nxt;

    // Sign-prefixed delay encoding
    function automatic logic [15:0] ildm_enc(input logic [10:0] d);
        logic [10:0] mag;
        mag = 11'(-d);
        if (d[10]) begin
            return {ildm_pkg::NEG_PREFIX, mag[8:0]}; // RL17
        end
        return {5'h00, d};
    endfunction : ildm_enc

    // Per-link delay and sync-loss
    logic [3:0][10:0] dly;
    logic [3:0][1:0]  lgrp;
    logic [3:0]       member;
    logic [3:0]       recomb;
    logic [3:0]       neg;
    logic [3:0]       link_delay_sync_loss_now;

    genvar gl;
    generate
        for (gl = 0; gl < ildm_pkg::NLINK; gl++) begin : g_link
            assign lgrp[gl]   = st_r.lctl[gl*ildm_pkg::LCTL_W + ildm_pkg::LCTL_GRP_LSB +: 2];
            assign member[gl] = st_r.lctl[gl*ildm_pkg::LCTL_W + ildm_pkg::LCTL_MEMBER_BIT];
            assign recomb[gl] = st_r.lctl[gl*ildm_pkg::LCTL_W + ildm_pkg::LCTL_RECOMB_BIT];
            assign dly[gl]    = link_wr_ptr[gl] - st_r.rd[lgrp[gl]]; // RL3
            assign neg[gl]    = dly[gl][10];
            assign link_delay_sync_loss_now[gl] = member[gl] & st_r.run[lgrp[gl]]
                & (neg[gl] | (dly[gl] > st_r.maxop[lgrp[gl]][10:0])); // RL7 RL9 RL10 RL11
        end
    endgenerate

    // Per-group extremes and suspend conditions
    logic [3:0][10:0] cmax;
    logic [3:0][10:0] cmin;
    logic [3:0][1:0]  cmax_ln;
    logic [3:0][1:0]  cmin_ln;
    logic [3:0]       any_mem;
    logic [3:0]       any_neg;
    logic [3:0]       all_ok;

    genvar gg;
    generate
        for (gg = 0; gg < ildm_pkg::NGRP; gg++) begin : g_grp
            always_comb begin
                cmax[gg]    = 11'h000;
                cmin[gg]    = 11'h000;
                cmax_ln[gg] = 2'h0;
                cmin_ln[gg] = 2'h0;
                any_mem[gg] = 1'b0;
                any_neg[gg] = 1'b0;
                all_ok[gg]  = 1'b1;
                for (int l = 0; l < ildm_pkg::NLINK; l++) begin
                    if (member[l] && lgrp[l] == 2'(gg)) begin
                        if (!any_mem[gg] || $signed(dly[l]) > $signed(cmax[gg])) begin
                            cmax[gg]    = dly[l];
                            cmax_ln[gg] = 2'(l);
                        end
                        if (!any_mem[gg] || $signed(dly[l]) < $signed(cmin[gg])) begin
                            cmin[gg]    = dly[l];
                            cmin_ln[gg] = 2'(l);
                        end
                        any_mem[gg] = 1'b1;
                        if (recomb[l] && neg[l]) begin
                            any_neg[gg] = 1'b1; // RL13 RL14
                        end
                        if (recomb[l] && $signed(dly[l]) < $signed(ildm_pkg::RESUME_CELLS)) begin
                            all_ok[gg] = 1'b0; // RL13 RL14
                        end
                    end
                end
            end
        end
    endgenerate

    // APB decode
    logic        acc;
    logic        wr_en;
    logic [11:0] idx;
    logic        mapped;
    logic [15:0] rdata;
    logic [1:0]  sel_num;
    logic [1:0]  sel_type;

    assign acc      = psel & penable & st_r.pready;
    assign wr_en    = acc & pwrite;
    assign idx      = paddr[13:2];
    assign sel_num  = st_r.sel[ildm_pkg::SEL_NUM_LSB +: 2];
    assign sel_type = st_r.sel[ildm_pkg::SEL_TYPE_LSB +: 2];

    always_comb begin
        rdata  = 16'h0000;
        mapped = 1'b1;
        if (idx >= ildm_pkg::IDX_GUARD_BASE && idx < ildm_pkg::IDX_GUARD_BASE + 12'h004) begin
            rdata = st_r.guard[2'(idx - ildm_pkg::IDX_GUARD_BASE)];
        end else if (idx >= ildm_pkg::IDX_MAXOP_BASE
                     && idx < ildm_pkg::IDX_MAXOP_BASE + 12'h004) begin
            rdata = st_r.maxop[2'(idx - ildm_pkg::IDX_MAXOP_BASE)];
        end else begin
            case (idx)
                ildm_pkg::IDX_DELAY_RESULT: rdata = st_r.res;
                ildm_pkg::IDX_DELAY_LINK:   rdata = st_r.res_ln;
                ildm_pkg::IDX_DELAY_SEL:    rdata = st_r.sel;
                ildm_pkg::IDX_IRQ_STS:      rdata = {8'h00, st_r.sts};
                ildm_pkg::IDX_IRQ_CLR:      rdata = 16'h0000;
                ildm_pkg::IDX_IRQ_EN:       rdata = {8'h00, st_r.irq_en};
                ildm_pkg::IDX_LINK_CTL:     rdata = st_r.lctl;
                ildm_pkg::IDX_GRP_RUN:      rdata = {12'h000, st_r.run};
                ildm_pkg::IDX_SUSP_STS:     rdata = {12'h000, st_r.susp};
                default:                    mapped = 1'b0;
            endcase
        end
    end

    // Next-state logic
    logic [7:0]  sts_set;
    logic [7:0]  sts_clr;
    logic [3:0]  run_new;
    logic [10:0] sel_val;
    logic [1:0]  sel_ln;

    always_comb begin
        st_nxt  = st_r;
        sts_clr = 8'h00;
        run_new = st_r.run;

        // Bus handshake: one wait-free access cycle per transfer
        st_nxt.pready  = psel & ~penable;
        st_nxt.pslverr = 1'b0;
        if (psel && !penable) begin
            st_nxt.prdata  = {16'h0000, rdata};
            st_nxt.pslverr = ~mapped;
        end

        st_nxt.pend = {st_r.pend[0], 1'b0};
        if (wr_en) begin
            if (idx >= ildm_pkg::IDX_GUARD_BASE
                && idx < ildm_pkg::IDX_GUARD_BASE + 12'h004) begin
                st_nxt.guard[2'(idx - ildm_pkg::IDX_GUARD_BASE)] = pwdata[15:0];
            end else if (idx >= ildm_pkg::IDX_MAXOP_BASE
                         && idx < ildm_pkg::IDX_MAXOP_BASE + 12'h004) begin
                st_nxt.maxop[2'(idx - ildm_pkg::IDX_MAXOP_BASE)] = pwdata[15:0]; // RL7
            end else begin
                case (idx)
                    ildm_pkg::IDX_DELAY_SEL: begin
                        st_nxt.sel  = pwdata[15:0] & ildm_pkg::SEL_WMASK;
                        st_nxt.sel[ildm_pkg::SEL_CLR_BIT] = 1'b0;
                        st_nxt.pend = {st_r.pend[0], 1'b1}; // RL1
                        if (pwdata[ildm_pkg::SEL_CLR_BIT]) begin
                            st_nxt.maxt_v[pwdata[ildm_pkg::SEL_NUM_LSB +: 2]] = 1'b0; // RL15
                        end
                    end
                    ildm_pkg::IDX_IRQ_CLR:  sts_clr       = pwdata[7:0];
                    ildm_pkg::IDX_IRQ_EN:   st_nxt.irq_en = pwdata[7:0];
                    ildm_pkg::IDX_LINK_CTL: st_nxt.lctl   = pwdata[15:0];
                    ildm_pkg::IDX_GRP_RUN:  run_new       = pwdata[3:0];
                    default: ;
                endcase
            end
        end
        st_nxt.run = run_new;

        // Read pointer: start-up placement, then advance per cell read
        for (int g = 0; g < ildm_pkg::NGRP; g++) begin
            if (run_new[g] && !st_r.run[g]) begin
                st_nxt.rd[g]   = st_r.rd[g] + cmin[g] - st_r.guard[g][10:0]; // RL4 RL6
                st_nxt.susp[g] = 1'b0;
            end else if (st_r.run[g]) begin
                if (grp_rd_adv[g] && !st_r.susp[g]) begin
                    st_nxt.rd[g] = st_r.rd[g] + 11'h001;
                end
                if (any_neg[g]) begin
                    st_nxt.susp[g] = 1'b1; // RL13 RL14
                end else if (st_r.susp[g] && all_ok[g]) begin
                    st_nxt.susp[g] = 1'b0; // RL13 RL14
                end
            end else begin
                st_nxt.susp[g] = 1'b0;
            end
            // Once-per-frame max over time
            if (frame_tick && st_r.run[g] && any_mem[g]) begin
                if (!st_nxt.maxt_v[g] || $signed(cmax[g]) > $signed(st_r.maxt[g])) begin
                    st_nxt.maxt[g]   = cmax[g];
                    st_nxt.maxt_v[g] = 1'b1;
                end
            end
        end

        // Sync-loss edges into sticky status; set beats clear
        sts_set = {link_delay_sync_loss_now & ~st_r.sync_loss, ~link_delay_sync_loss_now & st_r.sync_loss}; // RL12
        sts_set = {sts_set[3:0], sts_set[7:4]};
        st_nxt.sync_loss = link_delay_sync_loss_now;
        st_nxt.sts       = (st_r.sts & ~sts_clr) | sts_set; // RL12
        st_nxt.irq       = |(st_nxt.sts & st_r.irq_en); // RL12

        // Indirect result, latched two cycles after the selection write
        sel_val = 11'h000;
        sel_ln  = 2'h0;
        case (sel_type)
            ildm_pkg::ILDM_GRP_CUR_MAX: begin
                sel_val = cmax[sel_num];
                sel_ln  = cmax_ln[sel_num];
            end
            ildm_pkg::ILDM_GRP_CUR_MIN: begin
                sel_val = cmin[sel_num];
                sel_ln  = cmin_ln[sel_num];
            end
            ildm_pkg::ILDM_LINK_CUR: begin
                sel_val = dly[sel_num];
                sel_ln  = sel_num;
            end
            default: sel_val = st_r.maxt[sel_num];
        endcase
        if (st_r.pend[ildm_pkg::RESULT_LAT-1]) begin // RL1 RL2
            if (sel_type == ildm_pkg::ILDM_MAX_OVER_TIME) begin
                st_nxt.res    = st_r.maxt_v[sel_num] ? ildm_enc(sel_val)
                                                     : ildm_pkg::NEG_ZERO; // RL15
                st_nxt.res_ln = 16'h0000; // RL16
            end else begin
                st_nxt.res    = ildm_enc(sel_val); // RL16
                st_nxt.res_ln = {14'h0000, sel_ln};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r        <= '0;
            st_r.sel    <= ildm_pkg::SEL_RST;
            st_r.guard  <= {4{ildm_pkg::GUARD_RST}};
            st_r.maxop  <= {4{ildm_pkg::MAXOP_RST}};
            st_r.res    <= ildm_pkg::NEG_ZERO;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata      = st_r.prdata;
    assign pready      = st_r.pready;
    assign pslverr     = st_r.pslverr;
    assign grp_rd_ptr  = st_r.rd;
    assign grp_suspend = st_r.susp;
    assign irq         = st_r.irq;

endmodule : ildm_top
`default_nettype wire

// File: verif/ildm_checker.sv
// Protocol and pointer checks for the link delay monitor
`timescale 1ns/1ps
`default_nettype none
module ildm_checker (
    // Clock and reset
    input wire logic             pclk,
    input wire logic             presetn,
    // APB
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [13:0]      paddr,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    // Pointers and interrupt
    input wire logic [3:0]       grp_rd_adv,
    input wire logic [3:0][10:0] grp_rd_ptr,
    input wire logic [3:0]       grp_suspend,
    input wire logic             irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd_acc;
    logic wr_acc;
    assign rd_acc = pready && !pwrite && !pslverr;
    assign wr_acc = psel && penable && pwrite;
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_idle_no_ready: assert property (!psel |=> !pready)
        else $error("ready without select");
    a_err_with_ready: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error without ready or with data");
    a_upper_half_zero: assert property (pready |-> prdata[31:16] == 16'h0)
        else $error("upper read data not zero");
    a_data_holds: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved without setup");
    a_sel_clear_bit: assert property (rd_acc && paddr[13:2] == ildm_pkg::IDX_DELAY_SEL |->
        prdata[31:6] == 26'h0) else $error("selection readback wrong");
    a_result_code: assert property (rd_acc && paddr[13:2] == ildm_pkg::IDX_DELAY_RESULT |->
        prdata[15:11] == 5'h0 || prdata[15:9] == 7'h7F) else $error("delay encoding wrong");
    a_rd_step: assert property ($changed(grp_rd_ptr[0]) && !$past(wr_acc) && !$past(wr_acc, 2)
        |-> $past(grp_rd_adv[0] && !grp_suspend[0])
        && grp_rd_ptr[0] == $past(grp_rd_ptr[0]) + 11'h001)
        else $error("read pointer moved wrongly");
    c_suspend: cover property ($rose(grp_suspend[0]));
    c_irq: cover property ($rose(irq));
    c_err: cover property (pslverr);
    c_stall: cover property (grp_rd_adv[0] && grp_suspend[0]);
endmodule : ildm_checker
bind ildm_top ildm_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .grp_rd_adv(grp_rd_adv), .grp_rd_ptr(grp_rd_ptr),
    .grp_suspend(grp_suspend), .irq(irq));
`default_nettype wire

// File: verif/ildm_top_tb_top.sv
// Self-checking bench for the link delay monitor
`timescale 1ns/1ps
`default_nettype none
module ildm_top_tb_top;
    logic             pclk;
    logic             presetn;
    logic             psel;
    logic             penable;
    logic             pwrite;
    logic [13:0]      paddr;
    logic [31:0]      pwdata;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic [3:0][10:0] wr_ptr;
    logic [3:0]       rd_adv;
    logic             tick;
    logic [3:0][10:0] rd_ptr;
    logic [3:0]       susp;
    logic             irq;
    logic [31:0]      rdat;
    logic             rerr;
    int               mismatches = 0;
    int               compares = 0;

    ildm_top u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_wr_ptr(wr_ptr), .grp_rd_adv(rd_adv), .frame_tick(tick), .grp_rd_ptr(rd_ptr),
        .grp_suspend(susp), .irq(irq)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic print_verdict;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    task automatic apb(input logic wr, input logic [11:0] idx, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            print_verdict();
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [11:0] idx, input logic [31:0] exp, input string what);
        apb(1'b0, idx, 16'h0000);
        chk(what, exp, rdat);
    endtask : rdc

    task automatic pulse_adv;
        cyc(1);
        rd_adv[0] <= 1'b1;
        cyc(1);
        rd_adv[0] <= 1'b0;
        cyc(2);
    endtask : pulse_adv

    task automatic sel_wr(input logic [15:0] d);
        apb(1'b1, ildm_pkg::IDX_DELAY_SEL, d);
        cyc(ildm_pkg::RESULT_LAT);
    endtask : sel_wr

    task automatic t_reset_vals;
        rdc(ildm_pkg::IDX_DELAY_RESULT, 32'h0000FE00, "delay_result");
        rdc(ildm_pkg::IDX_DELAY_LINK, 32'h0, "link_number");
        rdc(ildm_pkg::IDX_GUARD_BASE, 32'h4, "guardband");
        rdc(ildm_pkg::IDX_MAXOP_BASE, 32'h7FF, "max_op");
        apb(1'b1, ildm_pkg::IDX_DELAY_RESULT, 16'h1234);
        rdc(ildm_pkg::IDX_DELAY_RESULT, 32'h0000FE00, "ro_result");
        rdc(12'h100, 32'h0, "unmapped_data");
        chk("unmapped_err", 32'h1, {31'h0, rerr});
        $display("test reset_values done");
    endtask : t_reset_vals

    task automatic t_start;
        logic [15:0] sel [3] = '{16'h0010, 16'h0020, 16'h0031};
        logic [31:0] dly [3] = '{32'hF, 32'h5, 32'hF};
        logic [31:0] lnk [3] = '{32'h1, 32'h0, 32'h1};
        apb(1'b1, ildm_pkg::IDX_GUARD_BASE, 16'h0005);
        apb(1'b1, ildm_pkg::IDX_LINK_CTL, 16'h00CC);
        apb(1'b1, ildm_pkg::IDX_GRP_RUN, 16'h0001);
        cyc(2);
        chk("rd_ptr_start", 32'h5, {21'h0, rd_ptr[0]});
        for (int i = 0; i < 3; i++) begin
            sel_wr(sel[i]);
            rdc(ildm_pkg::IDX_DELAY_RESULT, dly[i], "delay");
            rdc(ildm_pkg::IDX_DELAY_LINK, lnk[i], "link_number");
        end
        $display("test group_start done");
    endtask : t_start

    task automatic t_link_delay_sync_loss;
        apb(1'b1, ildm_pkg::IDX_IRQ_EN, 16'h0002);
        apb(1'b1, ildm_pkg::IDX_MAXOP_BASE + 12'h001, 16'h0004);
        cyc(3);
        rdc(ildm_pkg::IDX_IRQ_STS, 32'h0, "other_group_limit");
        apb(1'b1, ildm_pkg::IDX_MAXOP_BASE, 16'h000A);
        cyc(3);
        rdc(ildm_pkg::IDX_IRQ_STS, 32'h2, "link_delay_sync_loss_onset");
        chk("link_delay_sync_loss_no_susp", 32'h0, {31'h0, susp[0]});
        chk("irq_on", 32'h1, {31'h0, irq});
        apb(1'b1, ildm_pkg::IDX_IRQ_CLR, 16'h0002);
        cyc(3);
        chk("irq_cleared", 32'h0, {31'h0, irq});
        apb(1'b1, ildm_pkg::IDX_MAXOP_BASE, 16'h07FF);
        cyc(3);
        rdc(ildm_pkg::IDX_IRQ_STS, 32'h20, "link_delay_sync_loss_end");
        chk("irq_masked", 32'h0, {31'h0, irq});
        apb(1'b1, ildm_pkg::IDX_IRQ_CLR, 16'h00FF);
        $display("test sync_loss done");
    endtask : t_link_delay_sync_loss

    task automatic t_max_time;
        sel_wr(16'h0040);
        rdc(ildm_pkg::IDX_DELAY_SEL, 32'h0, "sel_readback");
        rdc(ildm_pkg::IDX_DELAY_RESULT, 32'h0000FE00, "max_time_clr");
        rdc(ildm_pkg::IDX_DELAY_LINK, 32'h0, "max_time_link");
        cyc(1);
        tick <= 1'b1;
        cyc(1);
        tick <= 1'b0;
        sel_wr(16'h0000);
        rdc(ildm_pkg::IDX_DELAY_RESULT, 32'hF, "max_time");
        rdc(ildm_pkg::IDX_DELAY_LINK, 32'h0, "max_time_link");
        $display("test max_over_time done");
    endtask : t_max_time

    task automatic t_negative;
        cyc(1);
        wr_ptr[0] <= 11'h004;
        cyc(3);
        chk("suspend_on", 32'h1, {31'h0, susp[0]});
        rdc(ildm_pkg::IDX_SUSP_STS, 32'h1, "susp_status");
        sel_wr(16'h0030);
        rdc(ildm_pkg::IDX_DELAY_RESULT, 32'h0000FE01, "neg_delay");
        rdc(ildm_pkg::IDX_IRQ_STS, 32'h1, "neg_onset");
        chk("irq_masked", 32'h0, {31'h0, irq});
        pulse_adv();
        chk("rd_stalled", 32'h5, {21'h0, rd_ptr[0]});
        wr_ptr[0] <= 11'h008;
        cyc(3);
        chk("suspend_at_3", 32'h1, {31'h0, susp[0]});
        wr_ptr[0] <= 11'h009;
        cyc(3);
        chk("suspend_off", 32'h0, {31'h0, susp[0]});
        pulse_adv();
        chk("rd_resumed", 32'h6, {21'h0, rd_ptr[0]});
        rdc(ildm_pkg::IDX_IRQ_STS, 32'h11, "neg_end");
        apb(1'b1, ildm_pkg::IDX_IRQ_EN, 16'h0010);
        cyc(2);
        chk("irq_end", 32'h1, {31'h0, irq});
        $display("test negative_delay done");
    endtask : t_negative

    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 14'h0;
        pwdata  = 32'h0;
        wr_ptr  = {11'h000, 11'h000, 11'h014, 11'h00A};
        rd_adv  = 4'h0;
        tick    = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_vals();
        t_start();
        t_link_delay_sync_loss();
        t_max_time();
        t_negative();
        print_verdict();
    end
endmodule : ildm_top_tb_top
`default_nettype wire
